// *** phy_mgmt_register_bank.sv ***
// Behaviour
// - registers are reached only by index through the access command/data port
// - indexes 0-6, 17, 18, 27, 29, 30, 31 are implemented
// - every management register is sixteen bits wide
// - control bit 15 starts a soft reset and clears itself when done
// - no field is persistent; a bit-15 soft reset reloads every control field
// - control bit 14 selects loopback, resets to zero
// - control bit 13 selects 100 Mbps, ignored while auto-negotiation enabled
// - control bit 12 enables auto-negotiation, overriding speed and duplex
// - speed and auto-negotiation enable reset from the speed strap level
// - control bit 11 selects power-down, resets to zero
// - after power-down clears, auto-negotiation completion sets status bit 5
// - control bit 9 restarts auto-negotiation and clears itself
// - control bit 8 selects full duplex, resets zero, ignored under auto-negotiation
// - control bit 7 enables the collision test, resets to zero
// - status bit 15 reads zero, bits 14 to 11 read one
// - status bits 3 and 0 read one
// - status bit 5 shows auto-negotiation complete, resets zero
// - status bit 4 is a latched-high remote fault flag
// - status bit 2 is a latched-low link flag, resets zero
// - status bit 1 is a latched-high jabber flag, resets zero
// - first identifier register returns fixed read-only OUI bits
`default_nettype none
module phy_mgmt_register_bank
    import phy_mgmt_pkg::*;
#(
    parameter logic [15:0] ID_HIGH       = ID_HIGH_DEFAULT,
    parameter int          RESET_CYCLES  = SOFT_RESET_CYCLES
)(
    input  wire logic         ref_clk,       // device clock, 25 MHz
    input  wire logic         arst_n,        // async reset, active low
    input  wire mgmt_req_type mgmt_req,      // indexed access request
    output var  mgmt_rsp_type mgmt_rsp,      // one-cycle answer
    input  wire logic         speed_strap,   // speed-default strap level
    input  wire logic         an_done,       // auto-negotiation finished
    input  wire logic         remote_fault,  // live remote fault
    input  wire logic         link_up,       // live link state
    input  wire logic         jabber,        // live jabber
    input  wire logic [15:0]  ext_rdata,     // data from other implemented indexes
    output var  logic         ext_sel,       // access targets another implemented index
    output var  phy_mode_type phy_mode,      // effective operating mode
    output var  logic         soft_reset_busy // soft reset in progress
);

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic is_ext_index(input logic [4:0] idx);
        return idx == IDX_IDENTIFIER_LOW || idx == IDX_AN_ADVERTISE
            || idx == IDX_AN_PARTNER || idx == IDX_AN_EXPANSION
            || idx == IDX_MODE_CTRL || idx == IDX_SPECIAL_MODES
            || idx == IDX_SPECIAL_IND || idx == IDX_IRQ_SOURCE
            || idx == IDX_IRQ_MASK || idx == IDX_SPECIAL_CTRL;
    endfunction

    logic wr_ctl;
    logic rd_sts;
    assign wr_ctl = mgmt_req.req && mgmt_req.write
                    && mgmt_req.index == IDX_BASIC_CONTROL;
    assign rd_sts = mgmt_req.req && !mgmt_req.write
                    && mgmt_req.index == IDX_BASIC_STATUS;

    // ------------------------------------------------------------
    // strap capture and soft reset sequencing
    // ------------------------------------------------------------
    // strap caught by a clocked process after release, never by the async reset
    localparam int CNT_W = $clog2(RESET_CYCLES + 1);
    logic             strap_taken;
    logic             strap_level;
    logic [CNT_W-1:0] rst_cnt;
    logic             soft_rst;
    logic             init_load;

    assign init_load = !strap_taken || (soft_rst && rst_cnt == '0);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strap_taken <= 1'b0;
            strap_level <= 1'b0;
        end
        else if (!strap_taken)
        begin
            strap_taken <= 1'b1;
            strap_level <= speed_strap;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soft_rst <= 1'b0;
            rst_cnt  <= '0;
        end
        else if (wr_ctl && mgmt_req.wdata[CTL_SOFT_RESET] && !soft_rst)
        begin
            soft_rst <= 1'b1;
            rst_cnt  <= CNT_W'(RESET_CYCLES - 1);
        end
        else if (soft_rst)
        begin
            if (rst_cnt == '0)
                soft_rst <= 1'b0;
            else
                rst_cnt <= rst_cnt - 1'b1;
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // no field is persistent, so soft reset reloads every field; writes
    // during the reset are dropped to keep the reload clean
    logic loopback;
    logic speed_100;
    logic an_enable;
    logic power_down;
    logic an_restart;
    logic full_duplex;
    logic col_test;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            loopback    <= CTL_RESET_VALUE[CTL_LOOPBACK];
            speed_100   <= CTL_RESET_VALUE[CTL_SPEED_100];
            an_enable   <= CTL_RESET_VALUE[CTL_AN_ENABLE];
            power_down  <= CTL_RESET_VALUE[CTL_POWER_DOWN];
            full_duplex <= CTL_RESET_VALUE[CTL_FULL_DUPLEX];
            col_test    <= CTL_RESET_VALUE[CTL_COL_TEST];
        end
        else if (init_load)
        begin
            loopback    <= CTL_RESET_VALUE[CTL_LOOPBACK];
            speed_100   <= strap_taken ? strap_level : speed_strap;
            an_enable   <= strap_taken ? strap_level : speed_strap;
            power_down  <= CTL_RESET_VALUE[CTL_POWER_DOWN];
            full_duplex <= CTL_RESET_VALUE[CTL_FULL_DUPLEX];
            col_test    <= CTL_RESET_VALUE[CTL_COL_TEST];
        end
        else if (wr_ctl && !soft_rst)
        begin
            loopback    <= mgmt_req.wdata[CTL_LOOPBACK];
            speed_100   <= mgmt_req.wdata[CTL_SPEED_100];
            an_enable   <= mgmt_req.wdata[CTL_AN_ENABLE];
            power_down  <= mgmt_req.wdata[CTL_POWER_DOWN];
            full_duplex <= mgmt_req.wdata[CTL_FULL_DUPLEX];
            col_test    <= mgmt_req.wdata[CTL_COL_TEST];
        end
    end

    // restart is a one-cycle pulse into the negotiation logic
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            an_restart <= 1'b0;
        else if (soft_rst)
            an_restart <= 1'b0;
        else if (wr_ctl && mgmt_req.wdata[CTL_AN_RESTART])
            an_restart <= 1'b1;
        else
            an_restart <= 1'b0;
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    logic an_complete;
    logic rf_latch;
    logic link_latch;
    logic jab_latch;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            an_complete <= 1'b0;
        else if (soft_rst || power_down || an_restart)
            an_complete <= 1'b0;
        else
            an_complete <= an_done;
    end

    // event in the read cycle wins over the read clear, so none is lost
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            rf_latch <= 1'b0;
        else if (soft_rst)
            rf_latch <= 1'b0;
        else
            rf_latch <= remote_fault || (rf_latch && !rd_sts);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            jab_latch <= 1'b0;
        else if (soft_rst)
            jab_latch <= 1'b0;
        else
            jab_latch <= jabber || (jab_latch && !rd_sts);
    end

    // a link drop in the read cycle wins, so a short outage still shows
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            link_latch <= 1'b0;
        else if (soft_rst)
            link_latch <= 1'b0;
        else
            link_latch <= link_up && (link_latch || rd_sts);
    end

    // ------------------------------------------------------------
    // read mux and outputs
    // ------------------------------------------------------------
    logic [15:0] ctl_value;
    logic [15:0] sts_value;
    logic [15:0] next_rdata;

    always_comb
    begin
        ctl_value = '0;
        ctl_value[CTL_SOFT_RESET]  = soft_rst;
        ctl_value[CTL_LOOPBACK]    = loopback;
        ctl_value[CTL_SPEED_100]   = speed_100;
        ctl_value[CTL_AN_ENABLE]   = an_enable;
        ctl_value[CTL_POWER_DOWN]  = power_down;
        ctl_value[CTL_AN_RESTART]  = an_restart;
        ctl_value[CTL_FULL_DUPLEX] = full_duplex;
        ctl_value[CTL_COL_TEST]    = col_test;
        sts_value = STS_FIXED_ONES;
        sts_value[STS_AN_COMPLETE]  = an_complete;
        sts_value[STS_REMOTE_FAULT] = rf_latch;
        sts_value[STS_LINK_UP]      = link_latch;
        sts_value[STS_JABBER]       = jab_latch;
        if (mgmt_req.index == IDX_BASIC_CONTROL)
            next_rdata = ctl_value;
        else if (mgmt_req.index == IDX_BASIC_STATUS)
            next_rdata = sts_value;
        else if (mgmt_req.index == IDX_IDENTIFIER_HIGH)
            next_rdata = ID_HIGH;
        else if (is_ext_index(mgmt_req.index))
            next_rdata = ext_rdata;
        else
            next_rdata = 16'h0000;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            mgmt_rsp <= '0;
        else
        begin
            mgmt_rsp.ack   <= mgmt_req.req;
            mgmt_rsp.rdata <= (mgmt_req.req && !mgmt_req.write) ? next_rdata : 16'h0000;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ext_sel <= 1'b0;
        else
            ext_sel <= mgmt_req.req && is_ext_index(mgmt_req.index);
    end

    // auto-negotiation overrides manual speed and duplex
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            phy_mode <= '0;
        else
        begin
            phy_mode.loopback    <= loopback;
            phy_mode.speed_100   <= an_enable ? 1'b0 : speed_100;
            phy_mode.full_duplex <= an_enable ? 1'b0 : full_duplex;
            phy_mode.power_down  <= power_down;
            phy_mode.col_test    <= col_test;
            phy_mode.an_enable   <= an_enable;
            phy_mode.an_restart  <= an_restart;
            phy_mode.soft_reset  <= soft_rst;
        end
    end

    // one cycle behind soft_rst; the reset bit itself reads ahead of it
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            soft_reset_busy <= 1'b0;
        else
            soft_reset_busy <= soft_rst;
    end

endmodule
`default_nettype wire

// *** phy_mgmt_pkg.sv ***
`default_nettype none
package phy_mgmt_pkg;

    // ------------------------------------------------------------
    // register indexes (hexadecimal)
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_BASIC_CONTROL   = 5'h00;
    localparam logic [4:0] IDX_BASIC_STATUS    = 5'h01;
    localparam logic [4:0] IDX_IDENTIFIER_HIGH = 5'h02;
    localparam logic [4:0] IDX_IDENTIFIER_LOW  = 5'h03;
    localparam logic [4:0] IDX_AN_ADVERTISE    = 5'h04;
    localparam logic [4:0] IDX_AN_PARTNER      = 5'h05;
    localparam logic [4:0] IDX_AN_EXPANSION    = 5'h06;
    localparam logic [4:0] IDX_MODE_CTRL       = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES   = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_IND     = 5'h1b;
    localparam logic [4:0] IDX_IRQ_SOURCE      = 5'h1d;
    localparam logic [4:0] IDX_IRQ_MASK        = 5'h1e;
    localparam logic [4:0] IDX_SPECIAL_CTRL    = 5'h1f;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTL_SOFT_RESET  = 15;
    localparam int CTL_LOOPBACK    = 14;
    localparam int CTL_SPEED_100   = 13;
    localparam int CTL_AN_ENABLE   = 12;
    localparam int CTL_POWER_DOWN  = 11;
    localparam int CTL_AN_RESTART  = 9;
    localparam int CTL_FULL_DUPLEX = 8;
    localparam int CTL_COL_TEST    = 7;

    // ------------------------------------------------------------
    // status field positions and fixed ability bits
    // ------------------------------------------------------------
    localparam int STS_AN_COMPLETE  = 5;
    localparam int STS_REMOTE_FAULT = 4;
    localparam int STS_LINK_UP      = 2;
    localparam int STS_JABBER       = 1;
    localparam logic [15:0] STS_FIXED_ONES = 16'h7809;

    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [15:0] CTL_RESET_VALUE = 16'h0000;
    // arbitrary identifier value, not tied to any maker
    localparam logic [15:0] ID_HIGH_DEFAULT = 16'h1234;
    localparam int SOFT_RESET_CYCLES = 16;

    // ------------------------------------------------------------
    // access port carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        req;
        logic        write;
        logic [4:0]  index;
        logic [15:0] wdata;
    } mgmt_req_type;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } mgmt_rsp_type;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic full_duplex;
        logic power_down;
        logic col_test;
        logic an_enable;
        logic an_restart;
        logic soft_reset;
    } phy_mode_type;

endpackage
`default_nettype wire

// *** phy_mgmt_register_bank_chk.sv ***
`default_nettype none
module phy_mgmt_register_bank_chk
    import phy_mgmt_pkg::*;
#(
    parameter logic [15:0] ID_HIGH = ID_HIGH_DEFAULT
)(
    input wire logic         ref_clk,        // device clock
    input wire logic         arst_n,         // async reset
    input wire mgmt_req_type mgmt_req,       // request
    input wire mgmt_rsp_type mgmt_rsp,       // answer
    input wire logic         ext_sel,        // other index hit
    input wire phy_mode_type phy_mode,       // effective mode
    input wire logic         soft_reset_busy // soft reset running
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    logic rd_req;
    logic wr_ctl_req;
    logic ext_idx;
    logic mapped_idx;
    assign rd_req = mgmt_req.req && !mgmt_req.write;
    assign wr_ctl_req = mgmt_req.req && mgmt_req.write && mgmt_req.index == 5'h00;
    assign ext_idx = mgmt_req.index inside {[5'h03:5'h06], 5'h11, 5'h12, 5'h1b, [5'h1d:5'h1f]};
    assign mapped_idx = ext_idx || mgmt_req.index inside {[5'h00:5'h02]};
    // ------------------------------------------------------------
    // access port
    // ------------------------------------------------------------
    a_ack_follows_req: assert property (mgmt_req.req |=> mgmt_rsp.ack)
        else $error("ack missing");
    a_no_stray_ack: assert property (!mgmt_req.req |=> !mgmt_rsp.ack)
        else $error("ack without request");
    a_ext_index_hit: assert property (rd_req && ext_idx |=> ext_sel && mgmt_rsp.ack)
        else $error("ext select missing");
    a_unmapped_zero: assert property (rd_req && !mapped_idx
        |=> mgmt_rsp.rdata == 16'h0000 && !ext_sel)
        else $error("unmapped read not zero");
    a_id_read: assert property (rd_req && mgmt_req.index == 5'h02 |=> mgmt_rsp.rdata == ID_HIGH)
        else $error("identifier wrong");
    a_status_fixed: assert property (rd_req && mgmt_req.index == 5'h01
        |=> (mgmt_rsp.rdata & 16'hffc9) == STS_FIXED_ONES)
        else $error("status fixed bits wrong");
    a_ctl_reserved: assert property (rd_req && mgmt_req.index == 5'h00
        |=> (mgmt_rsp.rdata & 16'h047f) == 16'h0000)
        else $error("control reserved bits set");
    // ------------------------------------------------------------
    // mode and soft reset
    // ------------------------------------------------------------
    a_an_override: assert property (phy_mode.an_enable
        |-> !phy_mode.speed_100 && !phy_mode.full_duplex)
        else $error("manual mode under auto-negotiation");
    a_restart_pulse: assert property ($rose(phy_mode.an_restart) |=> !phy_mode.an_restart)
        else $error("restart not self-clearing");
    // busy is registered from the reset state, so it shows two edges after the request
    a_sr_start: assert property (wr_ctl_req && mgmt_req.wdata[15] && !soft_reset_busy
        |-> ##2 soft_reset_busy)
        else $error("soft reset not started");
    a_sr_bounded: assert property ($rose(soft_reset_busy) |-> ##[1:300] !soft_reset_busy)
        else $error("soft reset stuck");
endmodule
bind phy_mgmt_register_bank phy_mgmt_register_bank_chk #(.ID_HIGH(ID_HIGH)) chk_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
    .ext_sel(ext_sel), .phy_mode(phy_mode), .soft_reset_busy(soft_reset_busy));
`default_nettype wire

// *** phy_mgmt_host.sv ***
`default_nettype none
module phy_mgmt_host
    import phy_mgmt_pkg::*;
(
    input  wire logic         ref_clk,  // device clock
    input  wire mgmt_rsp_type mgmt_rsp, // answer from bank
    output var  mgmt_req_type mgmt_req  // indexed access
);
    timeunit 1ns;
    timeprecision 1ps;
    initial mgmt_req = '0;
    // released fields show inverted values so stale data is never trusted
    task automatic access(input logic w, input logic [4:0] idx, input logic [15:0] d,
                          output logic [15:0] q, output logic ok);
        @(posedge ref_clk);
        mgmt_req <= '{req: 1'b1, write: w, index: idx, wdata: d};
        @(posedge ref_clk);
        mgmt_req <= '{req: 1'b0, write: ~w, index: ~idx, wdata: ~d};
        @(posedge ref_clk);
        q = mgmt_rsp.rdata;
        ok = mgmt_rsp.ack;
    endtask
endmodule
`default_nettype wire

// *** test_phy_mgmt_register_bank.sv ***
`default_nettype none
module test_phy_mgmt_register_bank;
    import phy_mgmt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ID_VAL = 16'h5a3c; // arbitrary value
    logic         ref_clk = 1'b0;
    logic         arst_n = 1'b0;
    logic         speed_strap = 1'b0;
    logic         an_done = 1'b0;
    logic         remote_fault = 1'b0;
    logic         link_up = 1'b0;
    logic         jabber = 1'b0;
    logic [15:0]  ext_rdata = 16'h0000;
    logic         ext_sel;
    logic         soft_reset_busy;
    mgmt_req_type mgmt_req;
    mgmt_rsp_type mgmt_rsp;
    phy_mode_type phy_mode;
    logic [15:0]  q;
    logic [15:0]  d;
    logic [15:0]  ctl;
    logic         ok;
    logic [4:0]   ext_idx [10] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h11, 5'h12, 5'h1b, 5'h1d,
                                   5'h1e, 5'h1f};
    int           failures = 0;
    int           n_checks = 0;
    always #20 ref_clk = ~ref_clk;
    phy_mgmt_host phy_mgmt_host_i (.ref_clk(ref_clk), .mgmt_rsp(mgmt_rsp), .mgmt_req(mgmt_req));
    phy_mgmt_register_bank #(.ID_HIGH(ID_VAL), .RESET_CYCLES(8)) phy_mgmt_register_bank_i (
        .ref_clk(ref_clk), .arst_n(arst_n), .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp),
        .speed_strap(speed_strap), .an_done(an_done), .remote_fault(remote_fault),
        .link_up(link_up), .jabber(jabber), .ext_rdata(ext_rdata), .ext_sel(ext_sel),
        .phy_mode(phy_mode), .soft_reset_busy(soft_reset_busy));
    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
        phy_mgmt_host_i.access(1'b0, idx, 16'h0000, q, ok);
        check("ack", {15'h0000, ok}, 16'h0001);
        check("read", q, exp);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [15:0] v);
        phy_mgmt_host_i.access(1'b1, idx, v, q, ok);
        check("ack", {15'h0000, ok}, 16'h0001);
    endtask
    function automatic logic [15:0] mode_of(input logic [15:0] c);
        return {8'h00, c[14], c[13] & !c[12], c[8] & !c[12], c[11], c[7], c[12], 2'b00};
    endfunction
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(38401));
        speed_strap <= 1'($urandom);
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        ctl = speed_strap ? 16'h3000 : 16'h0000;
        rd(5'h00, ctl);
        rd(5'h02, ID_VAL);
        wr(5'h02, 16'hffff);
        wr(5'h01, 16'h0000);
        rd(5'h02, ID_VAL);
        rd(5'h07, 16'h0000);
        rd(5'h1c, 16'h0000);
        foreach (ext_idx[i])
        begin
            ext_rdata <= 16'($urandom);
            @(posedge ref_clk);
            rd(ext_idx[i], ext_rdata);
        end
        repeat (6)
        begin
            d = 16'($urandom) & 16'h7fff;
            wr(5'h00, d);
            ctl = d & 16'h7980;
            rd(5'h00, ctl);
            check("mode", {8'h00, phy_mode}, mode_of(ctl));
        end
        // latched flags: first read drops whatever built up since reset
        wr(5'h00, 16'h1000);
        an_done <= 1'b1;
        link_up <= 1'b1;
        phy_mgmt_host_i.access(1'b0, 5'h01, 16'h0000, q, ok);
        rd(5'h01, STS_FIXED_ONES | 16'h0024);
        remote_fault <= 1'b1;
        jabber <= 1'b1;
        link_up <= 1'b0;
        @(posedge ref_clk);
        remote_fault <= 1'b0;
        jabber <= 1'b0;
        link_up <= 1'b1;
        rd(5'h01, STS_FIXED_ONES | 16'h0032);
        rd(5'h01, STS_FIXED_ONES | 16'h0024);
        wr(5'h00, 16'h1800);
        rd(5'h01, STS_FIXED_ONES | 16'h0004);
        wr(5'h00, 16'h1200);
        rd(5'h00, 16'h1000);
        rd(5'h01, STS_FIXED_ONES | 16'h0024);
        // soft reset, with a write during it that must be dropped
        wr(5'h00, 16'hc000);
        // busy trails the reset state by one register stage
        @(posedge ref_clk);
        check("busy", {15'h0000, soft_reset_busy}, 16'h0001);
        phy_mgmt_host_i.access(1'b0, 5'h00, 16'h0000, q, ok);
        check("reset bit", {15'h0000, q[15]}, 16'h0001);
        wr(5'h00, 16'h4000);
        for (int i = 0; i < 40 && soft_reset_busy !== 1'b0; i++)
            @(posedge ref_clk);
        check("busy end", {15'h0000, soft_reset_busy}, 16'h0000);
        rd(5'h00, speed_strap ? 16'h3000 : 16'h0000);
        arst_n <= 1'b0;
        speed_strap <= ~speed_strap;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd(5'h00, speed_strap ? 16'h3000 : 16'h0000);
        end_of_test();
    end
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        failures++;
        end_of_test();
    end
endmodule
`default_nettype wire
